// ### dv/ctr_model.sv
// Counter timer stand-in that counts cycles with the detector output high
`timescale 1ns/1ps
module ctr_model (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Detected events
    input wire upIn,
    output reg [15:0] upCount_r
);
    always @(posedge mclk)
    begin
        if (rst)
            upCount_r <= 16'h0000;
        else if (upIn)
            upCount_r <= upCount_r + 16'h0001;
    end
endmodule // ctr_model

// ### dv/pid_chk.sv
// Port checker for the pulse input event detector
`timescale 1ns/1ps
`include "pid_defs.vh"
module pid_chk #(
    parameter LATCH_N = 2,
    parameter EVENT_N = 4
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pins and outputs
    input wire pulseIn0,
    input wire pulseIn1,
    input wire [LATCH_N-1:0] latchIn,
    input wire [EVENT_N-1:0] eventIn,
    input wire detOut,
    input wire [LATCH_N-1:0] latchA,
    input wire [EVENT_N-1:0] eventLvl
);
    // Only custom and quad x4 up presets are tracked; others park the shadow
    reg [15:0] en_r;
    reg enOk_r;
    reg [2:0] quiet_r;
    reg [3:0] aq_r;
    reg [3:0] bq_r;
    wire wrDone = psel && penable && pready && pwrite;
    wire ok = enOk_r && quiet_r == 3'h7;
    function automatic hitf(input [15:0] e, input a, input ap, input b, input bp);
        reg ar, af, br, bf;
        begin
            ar = a & ~ap;
            af = ~a & ap;
            br = b & ~bp;
            bf = ~b & bp;
            hitf = |(e & {bf & a, bf & ~a, br & a, br & ~a, af & b, af & ~b, ar & b,
                ar & ~b, b, ~b, bf, br, a, ~a, af, ar});
        end
    endfunction
    // Pin sampled three edges back against its value one edge before that
    wire expHit = hitf(en_r, aq_r[2], aq_r[3], bq_r[2], bq_r[3]);
    always @(posedge mclk)
    begin
        aq_r <= {aq_r[2:0], pulseIn0};
        bq_r <= {bq_r[2:0], pulseIn1};
        quiet_r <= (rst || wrDone) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
        if (rst)
            en_r <= `PID_COND_RST;
        else if (wrDone && paddr == `PID_COND_OFS)
            en_r <= pwdata[15:0];
        else if (wrDone && paddr == `PID_MODE_OFS)
            en_r <= pwdata[3:0] == `PID_MODE_QUAD_X4_UP ? `PID_MASK_QUAD_X4_UP : 16'h0000;
        if (rst || (wrDone && paddr == `PID_COND_OFS))
            enOk_r <= 1'b1;
        else if (wrDone && paddr == `PID_MODE_OFS)
            enOk_r <= pwdata[3:0] == `PID_MODE_CUSTOM || pwdata[3:0] == `PID_MODE_QUAD_X4_UP;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready ##1 psel && penable && pready;
    endsequence
    property p_match(logic [15:0] keep);
        @(posedge mclk) disable iff (rst)
        ok && (en_r & ~keep) == 16'h0000 |-> detOut == expHit;
    endproperty
    a_plain_edge: assert property (p_match(16'h0033))
        else $error("edge condition output wrong");
    a_plain_level: assert property (p_match(16'h00cc))
        else $error("level condition output wrong");
    a_qual_edge: assert property (p_match(16'hff00))
        else $error("qualified edge output wrong");
    a_mixed_or: assert property (p_match(16'hffff))
        else $error("combined condition output wrong");
    a_one_wait: assert property (@(posedge mclk) disable iff (rst) s_setup |=> s_access)
        else $error("apb answer timing wrong");
    a_ready_pulse: assert property (@(posedge mclk) disable iff (rst) pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (@(posedge mclk) disable iff (rst)
        pready |-> pslverr == !(paddr == `PID_COND_OFS || paddr == `PID_MODE_OFS ||
        paddr == `PID_LEVEL_OFS || paddr == `PID_COUNT_OFS)) else $error("pslverr wrong");
    a_read_cond: assert property (@(posedge mclk) disable iff (rst)
        pready && !pwrite && paddr == `PID_COND_OFS && enOk_r |-> prdata[15:0] == en_r)
        else $error("enable readback wrong");
    a_latch_follow: assert property (@(posedge mclk) disable iff (rst)
        quiet_r == 3'h7 |-> latchA == $past(latchIn, 3)) else $error("latch level wrong");
    a_event_follow: assert property (@(posedge mclk) disable iff (rst)
        quiet_r == 3'h7 |-> eventLvl == $past(eventIn, 3)) else $error("event level wrong");
    a_reset_clear: assert property (@(posedge mclk)
        rst |=> !detOut && latchA == 0 && eventLvl == 0 && !pready)
        else $error("outputs not cleared by reset");
endmodule // pid_chk

// ### dv/tb_pulse_input_event_detector.sv
// Testbench for the pulse input event detector
`timescale 1ns/1ps
`include "pid_defs.vh"
module tb_pulse_input_event_detector;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg pulseIn0 = 1'b0;
    reg pulseIn1 = 1'b0;
    reg [1:0] latchIn = 2'h0;
    reg [3:0] eventIn = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, detOut;
    wire [1:0] latchA;
    wire [3:0] eventLvl;
    wire [15:0] upCount;
    reg [31:0] rdv;
    reg errv;
    integer fail_count = 0;
    integer check_count = 0;
    localparam [159:0] MASKS = {`PID_MASK_QUAD_X4_DN, `PID_MASK_QUAD_X4_UP,
        `PID_MASK_P2X2_DN, `PID_MASK_P2X2_UP, `PID_MASK_P2X1_DN, `PID_MASK_CW_DN,
        `PID_MASK_P1X2_DN, `PID_MASK_P1X2_UP, `PID_MASK_P1X1_DN, `PID_MASK_P1X1_UP};
    always #5 mclk = ~mclk;
    pulse_input_event_detector dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulseIn0(pulseIn0), .pulseIn1(pulseIn1), .latchIn(latchIn),
        .eventIn(eventIn), .detOut(detOut), .latchA(latchA), .eventLvl(eventLvl));
    ctr_model ctr_u (.mclk(mclk), .rst(rst), .upIn(detOut), .upCount_r(upCount));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp)
            begin
                fail_count = fail_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge mclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            n = 0;
            @(posedge mclk);
            while (pready !== 1'b1 && n < 20)
            begin
                @(posedge mclk);
                n = n + 1;
            end
            rdv = prdata;
            errv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            chk(n < 20, 1);
        end
    endtask
    task step(input a, input b);
        begin
            @(posedge mclk);
            pulseIn0 <= a;
            pulseIn1 <= b;
            repeat (7) @(posedge mclk);
        end
    endtask
    task quad(input integer n);
        repeat (n)
        begin
            step(1'b1, 1'b0);
            step(1'b1, 1'b1);
            step(1'b0, 1'b1);
            step(1'b0, 1'b0);
        end
    endtask
    task t_reset;
        begin
            apb(1'b0, `PID_COND_OFS, 32'h0);
            chk(rdv[15:0], `PID_COND_RST);
            apb(1'b0, `PID_MODE_OFS, 32'h0);
            chk(rdv[3:0], `PID_MODE_RST);
            apb(1'b0, 12'h010, 32'h0);
            chk({31'h0, errv}, 32'h1);
            chk(rdv, 32'h0);
            apb(1'b0, 12'h002, 32'h0);
            chk({31'h0, errv}, 32'h1);
            apb(1'b1, 12'h010, 32'hffff);
            chk({31'h0, errv}, 32'h1);
            apb(1'b0, `PID_COND_OFS, 32'h0);
            chk({31'h0, errv}, 32'h0);
            chk(rdv, 32'h0);
        end
    endtask
    task lv(input a, input b, input [1:0] l, input [3:0] e);
        begin
            @(posedge mclk);
            {pulseIn0, pulseIn1, latchIn, eventIn} <= {a, b, l, e};
            repeat (5) @(posedge mclk);
            chk(latchA, l);
            chk(eventLvl, e);
            apb(1'b0, `PID_LEVEL_OFS, 32'h0);
            chk(rdv, {20'h0, e, 2'h0, l, 2'h0, b, a});
        end
    endtask
    task t_levels;
        begin
            lv(1'b1, 1'b0, 2'h2, 4'h6);
            lv(1'b0, 1'b1, 2'h1, 4'h9);
            lv(1'b0, 1'b0, 2'h0, 4'h0);
        end
    endtask
    task t_modes;
        integer i;
        begin
            for (i = 1; i <= 10; i = i + 1)
            begin
                apb(1'b1, `PID_MODE_OFS, i);
                apb(1'b0, `PID_COND_OFS, 32'h0);
                chk(rdv[15:0], MASKS[16*i-16 +: 16]);
            end
            apb(1'b1, `PID_MODE_OFS, 32'hf);
            apb(1'b0, `PID_MODE_OFS, 32'h0);
            chk(rdv[3:0], `PID_MODE_QUAD_X4_DN);
            apb(1'b1, `PID_COND_OFS, {16'h0, `PID_MASK_QUAD_X4_DN});
            apb(1'b0, `PID_MODE_OFS, 32'h0);
            chk(rdv[3:0], `PID_MODE_QUAD_X4_DN);
            apb(1'b1, `PID_COND_OFS, 32'h1);
            apb(1'b0, `PID_MODE_OFS, 32'h0);
            chk(rdv[3:0], `PID_MODE_CUSTOM);
            apb(1'b1, `PID_MODE_OFS, `PID_MODE_CUSTOM);
            apb(1'b0, `PID_COND_OFS, 32'h0);
            chk(rdv[15:0], 16'h0000);
        end
    endtask
    task t_single;
        integer i;
        reg [15:0] c0, d;
        begin
            for (i = 0; i < 16; i = i + 1)
            begin
                apb(1'b1, `PID_COND_OFS, 32'h1 << i);
                repeat (6) @(posedge mclk);
                c0 = upCount;
                quad(1);
                repeat (6) @(posedge mclk);
                d = upCount - c0;
                // Level conditions run too but are judged by the checker
                if (i < 8 && 16'h0033 >> i & 1)
                    chk(d, 16'h0033 >> i & 1);
                else if (i >= 8)
                    chk(d, 16'h6933 >> i & 1);
            end
        end
    endtask
    task t_quad;
        reg [15:0] c0;
        begin
            apb(1'b1, `PID_MODE_OFS, `PID_MODE_QUAD_X4_UP);
            apb(1'b1, `PID_COUNT_OFS, 32'h0);
            c0 = upCount;
            quad(2);
            repeat (6) @(posedge mclk);
            apb(1'b0, `PID_COUNT_OFS, 32'h0);
            chk(rdv, 32'h8);
            apb(1'b1, `PID_COND_OFS, 32'h3);
            c0 = upCount;
            quad(1);
            repeat (6) @(posedge mclk);
            chk(upCount - c0, 16'h2);
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d errors %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_levels;
        t_modes;
        t_single;
        t_quad;
        end_sim;
    end
    // Whole run is about eleven hundred cycles; this limit is thirty thousand cycles
    initial
    begin
        #300000;
        fail_count = fail_count + 1;
        end_sim;
    end
endmodule // tb_pulse_input_event_detector
bind pulse_input_event_detector pid_chk #(.LATCH_N(LATCH_N), .EVENT_N(EVENT_N)) chk_u (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pulseIn0(pulseIn0), .pulseIn1(pulseIn1), .latchIn(latchIn), .eventIn(eventIn),
    .detOut(detOut), .latchA(latchA), .eventLvl(eventLvl));

// ### rtl/cond_detector.v
// Sixteen-condition edge and level detector on phase A and phase B
`timescale 1ns/1ps
`include "pid_defs.vh"
module cond_detector (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Synchronised phases and enables
    input wire phaseA,
    input wire phaseB,
    input wire [15:0] condEn,
    // Combinational hit, registered by the caller
    output wire hit
);
    reg prevA_r;
    reg prevB_r;
    wire aRise;
    wire aFall;
    wire bRise;
    wire bFall;
    wire [15:0] cond;

    // Edges against the level one clock earlier
    always @(posedge mclk)
    begin
        if (rst)
        begin
            prevA_r <= 1'b0;
            prevB_r <= 1'b0;
        end
        else
        begin
            prevA_r <= phaseA;
            prevB_r <= phaseB;
        end
    end

    assign aRise = phaseA & ~prevA_r;
    assign aFall = ~phaseA & prevA_r;
    assign bRise = phaseB & ~prevB_r;
    assign bFall = ~phaseB & prevB_r;

    assign cond[`PID_C_A_RISE] = aRise;
    assign cond[`PID_C_A_FALL] = aFall;
    assign cond[`PID_C_A_LOW] = ~phaseA;
    assign cond[`PID_C_A_HIGH] = phaseA;
    assign cond[`PID_C_B_RISE] = bRise;
    assign cond[`PID_C_B_FALL] = bFall;
    assign cond[`PID_C_B_LOW] = ~phaseB;
    assign cond[`PID_C_B_HIGH] = phaseB;
    assign cond[`PID_C_AR_BL] = aRise & ~phaseB;
    assign cond[`PID_C_AR_BH] = aRise & phaseB;
    assign cond[`PID_C_AF_BL] = aFall & ~phaseB;
    assign cond[`PID_C_AF_BH] = aFall & phaseB;
    assign cond[`PID_C_AL_BR] = bRise & ~phaseA;
    assign cond[`PID_C_AH_BR] = bRise & phaseA;
    assign cond[`PID_C_AL_BF] = bFall & ~phaseA;
    assign cond[`PID_C_AH_BF] = bFall & phaseA;

    assign hit = |(cond & condEn);
endmodule // cond_detector

// ### rtl/level_sync.v
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module level_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Levels
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            meta_r <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= pinIn;
            syncOut <= meta_r;
        end
    end
endmodule // level_sync

// ### rtl/pid_defs.vh
// Register map, field layout and preset constants of the pulse input event detector
`ifndef PID_DEFS_VH
`define PID_DEFS_VH

// Register byte offsets
`define PID_COND_OFS 12'h000
`define PID_MODE_OFS 12'h004
`define PID_LEVEL_OFS 12'h008
`define PID_COUNT_OFS 12'h00c

// Reset values
`define PID_COND_RST 16'h0000
`define PID_MODE_RST 4'h0
`define PID_COUNT_RST 16'h0000

// Level register fields
`define PID_LVL_A_BIT 0
`define PID_LVL_B_BIT 1
`define PID_LVL_DET_BIT 2
`define PID_LVL_LATCH_LSB 4
`define PID_LVL_EVENT_LSB 8

// Condition bit positions (enable register)
`define PID_C_A_RISE 0
`define PID_C_A_FALL 1
`define PID_C_A_LOW 2
`define PID_C_A_HIGH 3
`define PID_C_B_RISE 4
`define PID_C_B_FALL 5
`define PID_C_B_LOW 6
`define PID_C_B_HIGH 7
`define PID_C_AR_BL 8
`define PID_C_AR_BH 9
`define PID_C_AF_BL 10
`define PID_C_AF_BH 11
`define PID_C_AL_BR 12
`define PID_C_AH_BR 13
`define PID_C_AL_BF 14
`define PID_C_AH_BF 15

// Pulse input mode codes
`define PID_MODE_CUSTOM 4'h0
`define PID_MODE_P1X1_UP 4'h1
`define PID_MODE_P1X1_DN 4'h2
`define PID_MODE_P1X2_UP 4'h3
`define PID_MODE_P1X2_DN 4'h4
`define PID_MODE_CW_DN 4'h5
`define PID_MODE_P2X1_DN 4'h6
`define PID_MODE_P2X2_UP 4'h7
`define PID_MODE_P2X2_DN 4'h8
`define PID_MODE_QUAD_X4_UP 4'h9
`define PID_MODE_QUAD_X4_DN 4'ha

// Condition masks loaded by each preset
`define PID_MASK_P1X1_UP 16'h0100
`define PID_MASK_P1X1_DN 16'h0800
`define PID_MASK_P1X2_UP 16'h0500
`define PID_MASK_P1X2_DN 16'h0a00
`define PID_MASK_CW_DN 16'h1000
`define PID_MASK_P2X1_DN 16'h0400
`define PID_MASK_P2X2_UP 16'h0900
`define PID_MASK_P2X2_DN 16'h0600
`define PID_MASK_QUAD_X4_UP 16'h6900
`define PID_MASK_QUAD_X4_DN 16'h9600

`endif

// ### rtl/pulse_input_event_detector.v
// Pulse input event detector with input, latch and event terminals and an APB slave
// Functional notes
// - Each pulse terminal presents its input level, 0 or 1, to the detector.
// - Pulse input 0 is fixed to phase A, input 1 to phase B.
// - Sixteen-bit cell has two latch terminals, 32-bit one; latch 0->A, 1->B.
// - Latch terminals output their latch line level, feeding only the latch detector.
// - Sixteen-bit cell has four event terminals, 32-bit two; levels go to counter.
// - Sixteen condition enables reset OFF; output High when an enabled condition holds.
// - Selecting a preset loads all sixteen bits; later bit changes revert to custom.
// - A-rising enabled: one-cycle pulse on phase A rise, B ignored.
// - A-falling enabled: one-cycle pulse on phase A fall, B ignored.
// - A-low enabled: output High while phase A Low.
// - A-high enabled: output High while phase A High.
// - B-rising or B-falling enabled: one-cycle pulse on matching phase B edge.
// - B-low or B-high enabled: output High while phase B at that level.
// - A rise while B Low gives a one-cycle pulse.
// - A fall while B Low gives a one-cycle pulse.
// - A fall while B High gives a one-cycle pulse.
// - B rise while A Low gives a one-cycle pulse.
// - B rise while A High gives a one-cycle pulse.
// - B fall while A Low gives a one-cycle pulse.
// - B fall while A High gives a one-cycle pulse.
// - A rise while B High gives a one-cycle pulse.
// - Quad x4 up preset enables A-rise/B-low, A-fall/B-high, B-rise/A-high, B-fall/A-low.
`timescale 1ns/1ps
`include "pid_defs.vh"
module pulse_input_event_detector #(
    parameter LATCH_N = 2,
    parameter EVENT_N = 4
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Cell input pins
    input wire pulseIn0,
    input wire pulseIn1,
    input wire [LATCH_N-1:0] latchIn,
    input wire [EVENT_N-1:0] eventIn,
    // Towards latch detector and counter timer
    output reg detOut,
    output reg [LATCH_N-1:0] latchA,
    output reg [EVENT_N-1:0] eventLvl
);
    // Preset lookup; an unknown code loads nothing
    function [15:0] presetMask;
        input [3:0] mode;
        begin
            case (mode)
                `PID_MODE_P1X1_UP: presetMask = `PID_MASK_P1X1_UP;
                `PID_MODE_P1X1_DN: presetMask = `PID_MASK_P1X1_DN;
                `PID_MODE_P1X2_UP: presetMask = `PID_MASK_P1X2_UP;
                `PID_MODE_P1X2_DN: presetMask = `PID_MASK_P1X2_DN;
                `PID_MODE_CW_DN: presetMask = `PID_MASK_CW_DN;
                `PID_MODE_P2X1_DN: presetMask = `PID_MASK_P2X1_DN;
                `PID_MODE_P2X2_UP: presetMask = `PID_MASK_P2X2_UP;
                `PID_MODE_P2X2_DN: presetMask = `PID_MASK_P2X2_DN;
                `PID_MODE_QUAD_X4_UP: presetMask = `PID_MASK_QUAD_X4_UP;
                `PID_MODE_QUAD_X4_DN: presetMask = `PID_MASK_QUAD_X4_DN;
                default: presetMask = `PID_COND_RST;
            endcase
        end
    endfunction

    // Mode code validity check; writes of unknown codes are dropped
    function validMode;
        input [3:0] mode;
        begin
            validMode = (mode <= `PID_MODE_QUAD_X4_DN);
        end
    endfunction

    // Address decode, used for reads and writes
    function isMapped;
        input [11:0] addr;
        begin
            isMapped = (addr == `PID_COND_OFS) || (addr == `PID_MODE_OFS) ||
                (addr == `PID_LEVEL_OFS) || (addr == `PID_COUNT_OFS);
        end
    endfunction

    // Register map, one word each:
    //   COND  rw  sixteen condition enables, bit n-1 is condition n
    //   MODE  rw  preset code; a write of a known code loads the enables
    //   LEVEL ro  synchronised pins and the detector output
    //   COUNT ro  cycles with the detector output high; any write clears

    reg [15:0] condEn_r;
    reg [15:0] condEn_nxt;
    reg [3:0] mode_r;
    reg [3:0] mode_nxt;
    reg [15:0] count_r;
    reg [15:0] count_nxt;
    reg [31:0] rdMux;
    reg [31:0] levelWord;
    wire phaseA;
    wire phaseB;
    wire [LATCH_N-1:0] latchSync;
    wire [EVENT_N-1:0] eventSync;
    wire hit;
    wire accessPh;
    wire wrDone;
    wire countClr;
    // Decoded selects and strobes of the register bus
    wire rdTake;
    wire selCond;
    wire selMode;
    wire selLevel;
    wire selCount;
    wire wrCond;
    wire wrMode;
    wire condDiffers;

    // Pins cross into mclk before any logic sees them
    level_sync #(
        .WIDTH(2)
    ) u_pulseSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn({pulseIn1, pulseIn0}),
        .syncOut({phaseB, phaseA})
    );

    // Latch levels only pass through; the latch detector sits elsewhere
    level_sync #(
        .WIDTH(LATCH_N)
    ) u_latchSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(latchIn),
        .syncOut(latchSync)
    );

    // Event levels go to the counter timer with no further logic
    level_sync #(
        .WIDTH(EVENT_N)
    ) u_eventSync (
        .mclk(mclk),
        .rst(rst),
        .pinIn(eventIn),
        .syncOut(eventSync)
    );

    cond_detector u_det (
        .mclk(mclk),
        .rst(rst),
        .phaseA(phaseA),
        .phaseB(phaseB),
        .condEn(condEn_r),
        .hit(hit)
    );

    // APB: one wait state, so pready rises on the first access edge
    assign accessPh = psel & penable;
    assign wrDone = accessPh & pready & pwrite;
    // Read data is captured on the same edge that raises pready so it stands with it
    assign rdTake = accessPh & ~pready & ~pwrite;

    // Register selects; an unmapped address selects nothing
    assign selCond = (paddr == `PID_COND_OFS);
    assign selMode = (paddr == `PID_MODE_OFS);
    assign selLevel = (paddr == `PID_LEVEL_OFS);
    assign selCount = (paddr == `PID_COUNT_OFS);

    // Write strobes, valid only in the completing access cycle
    assign wrCond = wrDone & selCond;
    assign wrMode = wrDone & selMode & validMode(pwdata[3:0]);
    assign countClr = wrDone & selCount;
    assign condDiffers = (pwdata[15:0] != condEn_r);

    // Handshake: pready is a single-cycle pulse per transfer
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= accessPh & ~pready;
        end
    end

    // Unmapped addresses answer with an error; their writes change nothing
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= accessPh & ~pready & ~isMapped(paddr);
        end
    end

    // Read data holds until the next read, so a slow master still sees it
    always @(posedge mclk)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else if (rdTake)
        begin
            prdata <= rdMux;
        end
    end

    // Level word: pins as currently seen plus detector output
    always @*
    begin
        levelWord = 32'h00000000;
        levelWord[`PID_LVL_A_BIT] = phaseA;
        levelWord[`PID_LVL_B_BIT] = phaseB;
        levelWord[`PID_LVL_DET_BIT] = detOut;
        levelWord[`PID_LVL_LATCH_LSB +: LATCH_N] = latchSync;
        levelWord[`PID_LVL_EVENT_LSB +: EVENT_N] = eventSync;
    end

    // Read multiplexer; reserved bits and unmapped addresses read as zero
    always @*
    begin
        rdMux = 32'h00000000;
        if (selCond)
        begin
            rdMux[15:0] = condEn_r;
        end
        if (selMode)
        begin
            rdMux[3:0] = mode_r;
        end
        if (selLevel)
        begin
            rdMux = levelWord;
        end
        if (selCount)
        begin
            rdMux[15:0] = count_r;
        end
    end

    // A mode write loads the preset; an enable write that changes any bit
    // drops back to custom so the shown mode never disagrees with the bits
    always @*
    begin
        condEn_nxt = condEn_r;
        if (wrMode)
        begin
            condEn_nxt = presetMask(pwdata[3:0]);
        end
        else if (wrCond)
        begin
            condEn_nxt = pwdata[15:0];
        end
    end

    // Codes above the last preset are dropped without an error
    always @*
    begin
        mode_nxt = mode_r;
        if (wrMode)
        begin
            mode_nxt = pwdata[3:0];
        end
        else if (wrCond && condDiffers)
        begin
            mode_nxt = `PID_MODE_CUSTOM;
        end
    end

    // Detection counter saturates rather than wrapping, so a long level
    // condition cannot fold back to a small count; an event in the clearing
    // cycle still counts
    always @*
    begin
        if (countClr)
        begin
            count_nxt = `PID_COUNT_RST;
        end
        else
        begin
            count_nxt = count_r;
        end
        if (detOut && (count_nxt != 16'hffff))
        begin
            count_nxt = count_nxt + 16'h0001;
        end
    end

    // Configuration registers
    always @(posedge mclk)
    begin
        if (rst)
        begin
            condEn_r <= `PID_COND_RST;
            mode_r <= `PID_MODE_RST;
        end
        else
        begin
            condEn_r <= condEn_nxt;
            mode_r <= mode_nxt;
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            count_r <= `PID_COUNT_RST;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    // Outputs come straight from flops, one stage after the synchronisers
    always @(posedge mclk)
    begin
        if (rst)
        begin
            detOut <= 1'b0;
            latchA <= {LATCH_N{1'b0}};
            eventLvl <= {EVENT_N{1'b0}};
        end
        else
        begin
            detOut <= hit;
            latchA <= latchSync;
            eventLvl <= eventSync;
        end
    end
endmodule // pulse_input_event_detector
